// ---- rtl/adcp_pkg.sv ----
package adcp_pkg;

   // converter word and raw core code widths
   localparam int WORD_W = 15;
   localparam int RAW_W  = 17;
   localparam int MSB_POS = 14;
   localparam int LSB_POS = 0;

   // pipeline depth from sampling edge to output word
   localparam int LATENCY = 3;
   localparam logic [1:0] FILL_RESET = 2'h0;
   localparam logic [1:0] FILL_FULL  = 2'h3;

   // monitor buffer geometry
   localparam int FIFO_DEPTH = 8;
   localparam int FIFO_WIDTH = WORD_W + 1;

   // two's-complement full-scale codes
   localparam logic [WORD_W-1:0] POS_FS_CODE = 15'h3fff;
   localparam logic [WORD_W-1:0] NEG_FS_CODE = 15'h4000;
   localparam logic [WORD_W-1:0] WORD_RESET  = 15'h0000;
   localparam logic signed [RAW_W-1:0] POS_FS_RAW = 17'sh03fff;
   localparam logic signed [RAW_W-1:0] NEG_FS_RAW = 17'sh1c000;

   function automatic logic isOver(input logic signed [RAW_W-1:0] raw);
      return (raw > POS_FS_RAW) || (raw < NEG_FS_RAW);
   endfunction

   function automatic logic [WORD_W-1:0] clampWord(
      input logic signed [RAW_W-1:0] raw);
      if (raw > POS_FS_RAW) begin
         return POS_FS_CODE;
      end else if (raw < NEG_FS_RAW) begin
         return NEG_FS_CODE;
      end else begin
         return raw[WORD_W-1:0];
      end
   endfunction

endpackage

// ---- rtl/adcp_async_fifo.sv ----
module adcp_async_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input  wire logic             wrClk,
   input  wire logic             wrRst,
   input  wire logic             wrValid,
   input  wire logic [WIDTH-1:0] wrData,
   output logic                  wrReady,
   input  wire logic             rdClk,
   input  wire logic             rdRst,
   output logic                  rdValid,
   output logic [WIDTH-1:0]      rdData,
   input  wire logic             rdReady
);

   localparam int AW = $clog2(DEPTH);

   function automatic logic [AW:0] g2b(input logic [AW:0] g);
      logic [AW:0] b;
      b[AW] = g[AW];
      for (int i = AW - 1; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [WIDTH-1:0] mem_next [DEPTH];
   logic [AW:0]      wrBin_reg, wrBin_next, wrGray_reg;
   logic [AW:0]      rdBin_reg, rdBin_next, rdGray_reg;
   logic [AW:0]      rdGrayS1_reg, rdGrayS2_reg;
   logic [AW:0]      wrGrayS1_reg, wrGrayS2_reg;
   logic [AW:0]      wrLevel, rdLevel;

   ////////////////////////////////////////////////////////////////////////
   // write side, conversion clock
   always_comb begin
      wrLevel    = wrBin_reg - g2b(rdGrayS2_reg);
      wrReady    = (wrLevel != DEPTH[AW:0]);
      wrBin_next = wrBin_reg;
      mem_next   = mem_reg;
      if (wrValid && wrReady) begin
         mem_next[wrBin_reg[AW-1:0]] = wrData;
         wrBin_next = wrBin_reg + 1'b1;
      end
   end

   always_ff @(posedge wrClk or posedge wrRst) begin
      if (wrRst) begin
         wrBin_reg    <= '0;
         wrGray_reg   <= '0;
         rdGrayS1_reg <= '0;
         rdGrayS2_reg <= '0;
         for (int i = 0; i < DEPTH; i++) begin
            mem_reg[i] <= '0;
         end
      end else begin
         wrBin_reg    <= wrBin_next;
         wrGray_reg   <= wrBin_next ^ (wrBin_next >> 1);
         rdGrayS1_reg <= rdGray_reg;
         rdGrayS2_reg <= rdGrayS1_reg;
         mem_reg      <= mem_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read side, system clock
   always_comb begin
      rdLevel    = g2b(wrGrayS2_reg) - rdBin_reg;
      rdValid    = (rdLevel != '0);
      rdData     = mem_reg[rdBin_reg[AW-1:0]];
      rdBin_next = rdBin_reg;
      if (rdValid && rdReady) begin
         rdBin_next = rdBin_reg + 1'b1;
      end
   end

   always_ff @(posedge rdClk or posedge rdRst) begin
      if (rdRst) begin
         rdBin_reg    <= '0;
         rdGray_reg   <= '0;
         wrGrayS1_reg <= '0;
         wrGrayS2_reg <= '0;
      end else begin
         rdBin_reg    <= rdBin_next;
         rdGray_reg   <= rdBin_next ^ (rdBin_next >> 1);
         wrGrayS1_reg <= wrGray_reg;
         wrGrayS2_reg <= wrGrayS1_reg;
      end
   end

endmodule

// ---- rtl/adcp_sample_port.sv ----
// Contract
// - every rising conversion clock edge takes exactly one new sample.
// - a sample's result appears on the word three clock cycles later.
// - word and overrange flag stand stable at each strobe rising edge.
// - strobe rises after each falling clock edge, one pulse per period.
// - output word changes are launched from the rising clock edge.
// - each result is a 15-bit signed two's-complement word.
// - codes span positive to negative full scale; zero gives 0 or -1.
// - overrange flag is high when input passes either full-scale limit.
// - overrange flag has the same latency and timing as its word.
// - bit 14 is the sign bit, bit 0 the least significant bit.
module adcp_sample_port #(
   parameter int WORD_W = adcp_pkg::WORD_W,
   parameter int RAW_W  = adcp_pkg::RAW_W,
   parameter int DEPTH  = adcp_pkg::FIFO_DEPTH
) (
   input  wire logic              clk_sys,
   input  wire logic              rst,
   input  wire logic              convClockPos,
   input  wire logic [RAW_W-1:0]  analogIn,
   output logic [WORD_W-1:0]      sampleWord,
   output logic                   overrangeFlag,
   output logic                   sampleReadyStrobe,
   output logic                   fifoWrReady,
   output logic                   monValid,
   output logic [WORD_W-1:0]      monWord,
   output logic                   monOverrange,
   input  wire logic              monReady
);

   ////////////////////////////////////////////////////////////////////////
   // reset release into the conversion clock domain
   logic [1:0] convRstPipe_reg;
   logic       convRst;

   // assert at once, release only on a clean conversion edge
   always_ff @(posedge convClockPos or posedge rst) begin
      if (rst) begin
         convRstPipe_reg <= 2'h3;
      end else begin
         convRstPipe_reg <= {convRstPipe_reg[0], 1'b0};
      end
   end

   assign convRst = convRstPipe_reg[1];

   ////////////////////////////////////////////////////////////////////////
   // sampling pipeline on the conversion clock
   logic signed [RAW_W-1:0] stage1_reg, stage1_next;
   logic signed [RAW_W-1:0] stage2_reg, stage2_next;
   logic signed [RAW_W-1:0] stage3_reg, stage3_next;
   logic                    fillDone_reg, fillDone_next;
   logic [WORD_W-1:0]       word_reg, word_next;
   logic                    over_reg, over_next;
   logic [1:0]              fill_reg, fill_next;

   // the first two stages double as the pin synchroniser
   always_comb begin
      stage1_next = analogIn;
      stage2_next = stage1_reg;
      stage3_next = stage2_reg;
      word_next   = adcp_pkg::clampWord(stage3_reg);
      over_next   = adcp_pkg::isOver(stage3_reg);
      // word launched one edge after the count fills is the first real one
      fillDone_next = (fill_reg == adcp_pkg::FILL_FULL);
      fill_next   = fill_reg;
      if (fill_reg != adcp_pkg::FILL_FULL) begin
         fill_next = fill_reg + 2'h1;
      end
   end

   always_ff @(posedge convClockPos or posedge convRst) begin
      if (convRst) begin
         stage1_reg <= '0;
         stage2_reg <= '0;
         stage3_reg <= '0;
         word_reg   <= adcp_pkg::WORD_RESET;
         over_reg   <= 1'b0;
         fill_reg   <= adcp_pkg::FILL_RESET;
         fillDone_reg <= 1'b0;
      end else begin
         stage1_reg <= stage1_next;
         stage2_reg <= stage2_next;
         stage3_reg <= stage3_next;
         fillDone_reg <= fillDone_next;
         word_reg   <= word_next;
         over_reg   <= over_next;
         fill_reg   <= fill_next;
      end
   end

   // bit 14 sign, bit 0 lsb
   assign sampleWord    = word_reg;
   assign overrangeFlag = over_reg;

   ////////////////////////////////////////////////////////////////////////
   // sample-ready strobe: set on falling edge, cleared on rising edge
   logic strobeSet_reg, strobeSet_next;
   logic strobeClr_reg, strobeClr_next;

   // toggle pair keeps each flop on a single edge; the xor is glitch
   // free since only one of the two flops moves at a time
   always_comb begin
      strobeSet_next = ~strobeClr_reg;
      strobeClr_next = strobeSet_reg;
   end

   always_ff @(negedge convClockPos or posedge convRst) begin
      if (convRst) begin
         strobeSet_reg <= 1'b0;
      end else begin
         strobeSet_reg <= strobeSet_next;
      end
   end

   always_ff @(posedge convClockPos or posedge convRst) begin
      if (convRst) begin
         strobeClr_reg <= 1'b0;
      end else begin
         strobeClr_reg <= strobeClr_next;
      end
   end

   // strobe rises half a period after launch
   assign sampleReadyStrobe = strobeSet_reg ^ strobeClr_reg;

   ////////////////////////////////////////////////////////////////////////
   // monitor copy of the stream into the system clock domain
   logic                               pushValid;
   logic [adcp_pkg::FIFO_WIDTH-1:0]    popData;

   // words before the pipe is full are never pushed
   assign pushValid = fillDone_reg;

   // a converter cannot stall, so a full buffer drops words and shows
   // it on fifoWrReady
   adcp_async_fifo #(
      .WIDTH (adcp_pkg::FIFO_WIDTH),
      .DEPTH (DEPTH)
   ) uMonFifo (
      .wrClk   (convClockPos),
      .wrRst   (convRst),
      .wrValid (pushValid),
      .wrData  ({over_reg, word_reg}),
      .wrReady (fifoWrReady),
      .rdClk   (clk_sys),
      .rdRst   (rst),
      .rdValid (monValid),
      .rdData  (popData),
      .rdReady (monReady)
   );

   assign monWord      = popData[WORD_W-1:0];
   assign monOverrange = popData[WORD_W];

   ////////////////////////////////////////////////////////////////////////
   // checks on the conversion and system clocks
   logic fillDone;

   assign fillDone = fillDone_reg;

   AST_SAMPLE_EDGE: assert property (
      @(posedge convClockPos) disable iff (convRst)
      (fill_reg >= 2'h2) |-> (stage2_reg == $past(analogIn, 2)))
      else $error("sample not taken on each rising edge");

   AST_LATENCY: assert property (
      @(posedge convClockPos) disable iff (convRst)
      fillDone |-> (sampleWord == adcp_pkg::clampWord($past(analogIn, 4))))
      else $error("output word latency is not three cycles");

   AST_STAGE3: assert property (
      @(posedge convClockPos) disable iff (convRst)
      (fill_reg == adcp_pkg::FILL_FULL) |->
      (stage3_reg == $past(analogIn, 3)))
      else $error("third pipeline stage out of step");

   // sampled clock is still high at the edge that raises the strobe
   AST_STROBE_MID: assert property (
      @(posedge sampleReadyStrobe) disable iff (convRst)
      convClockPos)
      else $error("strobe rose away from the falling clock edge");

   AST_STROBE_LOW_HIGH: assert property (
      @(negedge convClockPos) disable iff (convRst)
      !sampleReadyStrobe)
      else $error("strobe high during clock high half");

   // converter side stays quiet while its reset is held
   AST_RESET_QUIET: assert property (
      @(posedge clk_sys)
      convRst |-> (!sampleReadyStrobe && !overrangeFlag &&
                   sampleWord == adcp_pkg::WORD_RESET))
      else $error("converter outputs active in reset");

   AST_STROBE_EACH: assert property (
      @(posedge convClockPos) disable iff (convRst)
      (fill_reg != adcp_pkg::FILL_RESET) |-> sampleReadyStrobe ##1
      sampleReadyStrobe)
      else $error("strobe missing in a clock period");

   AST_WORD_LAUNCH: assert property (
      @(posedge convClockPos) disable iff (convRst)
      (fillDone && $past(fillDone) &&
       adcp_pkg::clampWord($past(analogIn, 4)) !=
       adcp_pkg::clampWord($past(analogIn, 5))) |-> $changed(sampleWord))
      else $error("new word not launched on the rising edge");

   AST_POS_FULL: assert property (
      @(posedge convClockPos) disable iff (convRst)
      (fillDone && ($signed($past(analogIn, 4)) > adcp_pkg::POS_FS_RAW)) |->
      (sampleWord == adcp_pkg::POS_FS_CODE))
      else $error("positive full scale code wrong");

   AST_NEG_FULL: assert property (
      @(posedge convClockPos) disable iff (convRst)
      (fillDone && ($signed($past(analogIn, 4)) < adcp_pkg::NEG_FS_RAW)) |->
      (sampleWord == adcp_pkg::NEG_FS_CODE))
      else $error("negative full scale code wrong");

   AST_OVERRANGE: assert property (
      @(posedge convClockPos) disable iff (convRst)
      fillDone |-> (overrangeFlag == adcp_pkg::isOver($past(analogIn, 4))))
      else $error("overrange flag does not match sample");

   AST_IN_RANGE_LOW: assert property (
      @(posedge convClockPos) disable iff (convRst)
      (fillDone && !adcp_pkg::isOver($past(analogIn, 4))) |->
      !overrangeFlag)
      else $error("overrange flag high for in-range sample");

   AST_OVR_ALIGN: assert property (
      @(posedge convClockPos) disable iff (convRst)
      overrangeFlag |-> (sampleWord == adcp_pkg::POS_FS_CODE ||
                         sampleWord == adcp_pkg::NEG_FS_CODE))
      else $error("overrange flag not aligned with its word");

   AST_SIGN_BIT: assert property (
      @(posedge convClockPos) disable iff (convRst)
      fillDone |-> (sampleWord[adcp_pkg::MSB_POS] ==
                    ($signed($past(analogIn, 4)) < 0)))
      else $error("bit 14 is not the sign");

   AST_WORD_ECHO: assert property (
      @(posedge convClockPos) disable iff (convRst)
      (fillDone && !adcp_pkg::isOver($past(analogIn, 4))) |->
      (sampleWord == $past(analogIn[WORD_W-1:0], 4)))
      else $error("in-range word bits are not the sample");

   AST_NO_EARLY_PUSH: assert property (
      @(posedge convClockPos) disable iff (convRst)
      $rose(fillDone) |-> $past(fill_reg == adcp_pkg::FILL_FULL))
      else $error("buffer filled before pipeline");

   // a waiting head entry must not move under the reader
   AST_MON_HOLD: assert property (
      @(posedge clk_sys) disable iff (rst)
      (monValid && !monReady) |=> (monValid && $stable(monWord)))
      else $error("monitor head changed while waiting");

   COV_WARM_DONE: cover property (
      @(posedge convClockPos) disable iff (convRst)
      $rose(fillDone));

   COV_OVERRANGE: cover property (
      @(posedge convClockPos) disable iff (convRst)
      fillDone && overrangeFlag);

   COV_FIFO_FULL: cover property (
      @(posedge convClockPos) disable iff (convRst)
      pushValid && !fifoWrReady);

   COV_MON_POP: cover property (
      @(posedge clk_sys) disable iff (rst)
      monValid && monReady ##1 monValid && monReady);

   COV_SIGN_FLIP: cover property (
      @(posedge convClockPos) disable iff (convRst)
      fillDone && $changed(sampleWord[adcp_pkg::MSB_POS]));

endmodule

// ---- dv/adcp_capture_model.sv ----
module adcp_capture_model (
   input  wire logic        rst,
   input  wire logic        strobe,
   input  wire logic [14:0] word,
   input  wire logic        flag,
   output logic [14:0]      capWord,
   output logic             capFlag,
   output logic [7:0]       capCount
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [1:0] skipCnt;

   always @(posedge strobe or posedge rst) begin
      if (rst) begin
         skipCnt <= 2'h0;
         capCount <= 8'h00;
         capWord <= 15'h0000;
         capFlag <= 1'b0;
      end else if (skipCnt != 2'h3) begin
         skipCnt <= skipCnt + 2'h1;
      end else begin
         capWord <= word;
         capFlag <= flag;
         capCount <= capCount + 8'h01;
      end
   end
endmodule

// ---- dv/testbench.sv ----
module testbench;
   timeunit 1ns;
   timeprecision 100ps;

   logic        clk_sys = 1'b0;
   logic        convClockPos = 1'b0;
   logic        rst = 1'b1;
   logic [16:0] analogIn = 17'h00000;
   logic        monReady = 1'b0;
   logic        ramping = 1'b0;
   logic [14:0] sampleWord;
   logic [14:0] monWord;
   logic [14:0] capWord;
   logic        overrangeFlag;
   logic        sampleReadyStrobe;
   logic        fifoWrReady;
   logic        monValid;
   logic        monOverrange;
   logic        capFlag;
   logic [7:0]  capCount;
   int          fail_count = 0;
   int          checks = 0;
   logic [16:0] vals [10] = '{17'h00000, 17'h1ffff, 17'h03fff, 17'h1c000,
      17'h04000, 17'h1bfff, 17'h00005, 17'h1fffb, 17'h0ffff, 17'h10000};

   always #12.5 clk_sys = ~clk_sys;

   // high time is half the period
   initial begin
      #7;
      forever #32 convClockPos = ~convClockPos;
   end

   always @(negedge convClockPos) begin
      if (ramping) analogIn <= analogIn + 17'h00001;
   end

   adcp_sample_port adcp_sample_port_inst (
      .clk_sys(clk_sys), .rst(rst), .convClockPos(convClockPos),
      .analogIn(analogIn), .sampleWord(sampleWord),
      .overrangeFlag(overrangeFlag), .sampleReadyStrobe(sampleReadyStrobe),
      .fifoWrReady(fifoWrReady), .monValid(monValid), .monWord(monWord),
      .monOverrange(monOverrange), .monReady(monReady));

   adcp_capture_model adcp_capture_model_inst (
      .rst(rst), .strobe(sampleReadyStrobe), .word(sampleWord),
      .flag(overrangeFlag), .capWord(capWord), .capFlag(capFlag),
      .capCount(capCount));

   ////////////////////////////////////////////////////////////////////////
   task automatic cmpWord(input logic [14:0] got, exp, input string msg);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   task automatic cmpBit(input logic got, exp, input string msg);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %0t %s got %b exp %b", $time, msg, got, exp);
      end
   endtask

   // {flag, word}; outside the table means the idle input of zero
   function automatic logic [15:0] expAt(input int k);
      logic signed [16:0] v;
      if (k < 0 || k > 9) return 16'h0000;
      v = vals[k];
      if (v > 17'sh03fff) return 16'hbfff;
      if (v < 17'sh1c000) return 16'hc000;
      return {1'b0, v[14:0]};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   task automatic test_stream();
      logic [15:0] e;
      for (int i = 0; i < 14; i++) begin
         @(negedge convClockPos);
         analogIn = (i < 10) ? vals[i] : 17'h00000;
         #1;
         e = expAt(i - 4);
         cmpWord(capWord, e[14:0], "captured word");
         cmpBit(capFlag, e[15], "captured flag");
         cmpWord(sampleWord, capWord, "word at strobe");
         cmpBit(overrangeFlag, capFlag, "flag at strobe");
         cmpBit(sampleReadyStrobe, 1'b1, "strobe low half");
         @(posedge convClockPos);
         #1;
         e = expAt(i - 3);
         cmpWord(sampleWord, e[14:0], "launch at rise");
         cmpBit(overrangeFlag, e[15], "flag at rise");
         cmpBit(sampleReadyStrobe, 1'b0, "strobe high half");
      end
      $display("test stream done");
   endtask

   task automatic test_fifo();
      logic [14:0] prev;
      int n;
      ramping = 1'b1;
      @(negedge clk_sys);
      monReady = 1'b1;
      repeat (10) @(negedge convClockPos);
      // far side stalls while the buffer fills
      @(negedge clk_sys);
      monReady = 1'b0;
      repeat (14) @(negedge convClockPos);
      #1;
      cmpBit(fifoWrReady, 1'b0, "buffer full");
      cmpBit(monValid, 1'b1, "buffer valid");
      for (int i = 0; i < 8; i++) begin
         @(negedge clk_sys);
         if (i > 0) cmpWord(monWord, prev + 15'h0001, "buffer order");
         prev = monWord;
         cmpBit(monOverrange, 1'b0, "buffer flag");
         monReady = 1'b1;
         @(negedge clk_sys);
         monReady = 1'b0;
      end
      monReady = 1'b1;
      n = 0;
      while (monValid !== 1'b0 && n < 60) begin
         @(negedge clk_sys);
         n++;
      end
      cmpBit(monValid, 1'b0, "buffer drained");
      monReady = 1'b0;
      ramping = 1'b0;
      $display("test fifo done");
   endtask

   task automatic test_reset();
      @(negedge convClockPos);
      analogIn = 17'h00777;
      @(negedge clk_sys);
      rst = 1'b1;
      #1;
      cmpWord(sampleWord, 15'h0000, "reset word");
      cmpBit(overrangeFlag, 1'b0, "reset flag");
      cmpBit(sampleReadyStrobe, 1'b0, "reset strobe");
      cmpBit(monValid, 1'b0, "reset valid");
      cmpBit(fifoWrReady, 1'b1, "reset ready");
      repeat (2) @(posedge convClockPos);
      @(negedge clk_sys);
      rst = 1'b0;
      repeat (3) begin
         @(posedge sampleReadyStrobe);
         #1;
         cmpWord(sampleWord, 15'h0000, "warm-up word");
      end
      repeat (8) @(posedge convClockPos);
      #1;
      cmpWord(capWord, 15'h0777, "after restart");
      cmpWord({7'h00, capCount}, 15'h0007, "capture count");
      $display("test reset done");
   endtask

   task automatic wrap_up();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // whole run is a few microseconds
   initial begin
      #60000;
      fail_count++;
      $display("MISMATCH %0t watchdog expired", $time);
      wrap_up();
   end

   initial begin
      repeat (2) @(negedge clk_sys);
      // converter side needs two of its own edges in reset too
      repeat (2) @(posedge convClockPos);
      @(negedge clk_sys);
      rst = 1'b0;
      repeat (6) @(posedge convClockPos);
      test_stream();
      test_fifo();
      test_reset();
      wrap_up();
   end
endmodule
